// >>> inc/bus_arb_pkg.sv
// Package: cycle kinds, bus states, arbiter state record and reset values
package bus_arb_pkg;

    // *********************************************
    // Bus cycle kinds and bus states
    // *********************************************
    typedef enum logic [2:0] {
        K_MEMRD, K_IORD, K_FETCH, K_IRQ_ACKNOWLEDGE, K_MEMWR, K_IOWR, K_HALT, K_REFRESH
    } kind_t;

    typedef enum logic [3:0] {
        S_IDLE, S_T1, S_T2, S_T3, S_T4, S_HALT, S_GRANT, S_HOLD, S_YIELD
    } busst_t;

    // Reads that reload the code segment and pointer after halt
    localparam logic [1:0] RELOAD_READS = 2'h2;
    localparam logic [1:0] RELOAD_NONE = 2'h0;
    localparam logic [1:0] RELOAD_STEP = 2'h1;

    // *********************************************
    // Whole arbiter state
    // *********************************************
    typedef struct packed {
        busst_t bst;
        kind_t kind;
        logic testMeta;
        logic testSync;
        logic refPend;
        logic lockArm;
        logic lockEnd;
        logic lockOn;
        logic intaSeq;
        logic intaSecond;
        logic haltRet;
        logic [1:0] reloadCnt;
        logic grant;
        logic ctrlFlt;
        logic dataFlt;
        logic dir;
        logic lock_n;
        logic suspend;
        logic halted;
        logic cycStart;
        logic cycDone;
        logic irqAccept;
    } st_t;

    localparam st_t ST_RESET = '{
        bst: S_IDLE, kind: K_MEMRD, testMeta: 1'h0, testSync: 1'h0,
        refPend: 1'h0, lockArm: 1'h0, lockEnd: 1'h0, lockOn: 1'h0,
        intaSeq: 1'h0, intaSecond: 1'h0, haltRet: 1'h0, reloadCnt: 2'h0,
        grant: 1'h0, ctrlFlt: 1'h0, dataFlt: 1'h0, dir: 1'h1, lock_n: 1'h1,
        suspend: 1'h0, halted: 1'h0, cycStart: 1'h0, cycDone: 1'h0,
        irqAccept: 1'h0
    };

endpackage

// >>> verilog/bus_hold_lock_halt_arbiter.sv
// Bus ownership, lock, halt and wait arbiter of the bus interface unit
`timescale 1ns/1ns

module bus_hold_lock_halt_arbiter
    import bus_arb_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic holdReq,
    input wire logic refreshReq,
    input wire logic nmiReq,
    input wire logic irqReq,
    input wire logic testIn,
    input wire logic waitExec,
    input wire logic lockPrefix,
    input wire logic lockedInstrDone,
    input wire logic prefixActive,
    input wire logic repString,
    input wire logic cycleReq,
    input wire kind_t cycleKind,
    input wire logic oddSecond,
    input wire logic ready,
    input wire logic powerDown,
    output logic busGrantOut,
    output logic lockOut_n,
    output logic transceiverDirection,
    output logic ctrlFloat,
    output logic dataFloat,
    output logic execSuspended,
    output logic haltActive,
    output logic busCycleStart,
    output logic busCycleDone,
    output kind_t cycleKindOut,
    output logic irqAccept
);

    // *********************************************
    // State and arbitration terms
    // *********************************************
    st_t q;
    st_t n;
    logic locked;
    logic exempt;
    logic intOk;
    logic refOk;
    logic holdOk;
    logic refNew;

    assign locked = q.lockOn | q.intaSeq;
    // Halt, wait and repeat string take interrupts mid-instruction
    assign exempt = repString | waitExec | (q.bst == S_HALT);
    assign intOk = (nmiReq | irqReq) & (~prefixActive | exempt);
    assign refOk = q.refPend & ~locked & (~prefixActive | exempt);
    assign holdOk = holdReq & ~locked;
    // Refresh posted at this edge, not yet recorded as pending
    assign refNew = refreshReq & ~locked & (~prefixActive | exempt);

    // *********************************************
    // Start of a bus cycle at T1
    // *********************************************
    function automatic st_t launch(input st_t s, input kind_t k);
        st_t r;
        r = s;
        r.bst = S_T1;
        r.kind = k;
        r.cycStart = 1'b1;
        r.dir = !(k inside {K_MEMRD, K_IORD, K_FETCH, K_IRQ_ACKNOWLEDGE});
        if (s.lockArm) begin
            r.lockOn = 1'b1;
            r.lockArm = 1'b0;
        end else if (s.lockEnd) begin
            r.lockOn = 1'b0;
            r.lockEnd = 1'b0;
        end
        if (k == K_IRQ_ACKNOWLEDGE) begin
            r.intaSeq = 1'b1;
        end
        if (k == K_REFRESH) begin
            r.refPend = 1'b0;
        end
        return r;
    endfunction

    // Choice at a cycle boundary: refresh, hold, halt return, reload, request
    function automatic st_t pick(input st_t s);
        st_t r;
        r = s;
        r.bst = S_IDLE;
        if (refOk) begin
            r = launch(s, K_REFRESH);
        end else if (refNew) begin
            r.bst = S_IDLE;
        end else if (holdOk) begin
            r.ctrlFlt = 1'b1;
            r.bst = S_GRANT;
        end else if (s.haltRet) begin
            r.haltRet = 1'b0;
            r.bst = S_HALT;
        end else if (s.reloadCnt != RELOAD_NONE) begin
            r = launch(s, K_MEMRD);
            r.reloadCnt = s.reloadCnt - RELOAD_STEP;
        end else if (cycleReq) begin
            r = launch(s, cycleKind);
        end
        return r;
    endfunction

    // *********************************************
    // Next state
    // *********************************************
    always_comb begin
        n = q;
        n.testMeta = testIn;
        n.testSync = q.testMeta;
        n.cycStart = 1'b0;
        n.cycDone = 1'b0;
        n.irqAccept = intOk;
        unique case (q.bst)
            S_IDLE: begin
                n = pick(n);
            end
            S_T1: begin
                n.bst = S_T2;
            end
            S_T2: begin
                n.bst = S_T3;
            end
            S_T3: begin
                if (ready) begin
                    n.bst = S_T4;
                end
            end
            S_T4: begin
                n.cycDone = 1'b1;
                if (q.kind == K_HALT) begin
                    n.bst = S_HALT;
                end else if (q.kind == K_IRQ_ACKNOWLEDGE && !q.intaSecond) begin
                    n.intaSecond = 1'b1;
                    n = launch(n, K_IRQ_ACKNOWLEDGE);
                end else if (oddSecond && q.kind != K_IRQ_ACKNOWLEDGE) begin
                    n = launch(n, cycleKind);
                end else begin
                    if (q.kind == K_IRQ_ACKNOWLEDGE) begin
                        n.intaSeq = 1'b0;
                        n.intaSecond = 1'b0;
                    end
                    n = pick(n);
                end
            end
            S_HALT: begin
                if (intOk) begin
                    n.bst = S_IDLE;
                    n.reloadCnt = RELOAD_READS;
                end else if (!powerDown && (refOk || holdOk)) begin
                    n.haltRet = 1'b1;
                    n = pick(n);
                end
            end
            S_GRANT: begin
                n.grant = 1'b1;
                n.dataFlt = 1'b1;
                n.bst = S_HOLD;
            end
            S_HOLD: begin
                if (q.refPend) begin
                    n.grant = 1'b0;
                    n.bst = S_YIELD;
                end else if (!holdReq) begin
                    n.grant = 1'b0;
                    n.ctrlFlt = 1'b0;
                    n.dataFlt = 1'b0;
                    n.bst = S_IDLE;
                end
            end
            S_YIELD: begin
                if (!holdReq) begin
                    n.ctrlFlt = 1'b0;
                    n.dataFlt = 1'b0;
                    n.bst = S_IDLE;
                end
            end
            default: begin
                n.bst = S_IDLE;
            end
        endcase
        // Events arriving with their clear are kept
        if (refreshReq) begin
            n.refPend = 1'b1;
        end
        if (lockPrefix) begin
            n.lockArm = 1'b1;
        end
        if (lockedInstrDone || (intOk && q.lockOn && repString)) begin
            n.lockEnd = 1'b1;
        end
        n.suspend = waitExec & q.testSync & ~intOk;
        n.lock_n = ~(n.lockOn | n.intaSeq);
        n.halted = (n.bst == S_HALT);
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= ST_RESET;
        end else begin
            q <= n;
        end
    end

    assign busGrantOut = q.grant;
    assign lockOut_n = q.lock_n;
    assign transceiverDirection = q.dir;
    assign ctrlFloat = q.ctrlFlt;
    assign dataFloat = q.dataFlt;
    assign execSuspended = q.suspend;
    assign haltActive = q.halted;
    assign busCycleStart = q.cycStart;
    assign busCycleDone = q.cycDone;
    assign cycleKindOut = q.kind;
    assign irqAccept = q.irqAccept;

    // *********************************************
    // Checks
    // *********************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence sq_floatGrant;
        q.ctrlFlt && !q.grant ##1 q.grant && q.dataFlt && q.ctrlFlt;
    endsequence

    sequence sq_haltLeft;
        q.bst != S_HALT && q.reloadCnt == RELOAD_READS;
    endsequence

    a_grant_latency: assert property (
        q.bst == S_IDLE && holdOk && !refOk && !refNew |=> sq_floatGrant)
        else $error("hold grant not given in two clocks");

    a_float_before: assert property (
        $rose(q.grant) |-> $past(q.ctrlFlt) && !$past(q.dataFlt))
        else $error("control lines not floated before grant");

    a_read_direction: assert property (
        q.bst inside {S_T2, S_T3, S_T4} |->
        q.dir == !(q.kind inside {K_MEMRD, K_IORD, K_FETCH, K_IRQ_ACKNOWLEDGE}))
        else $error("direction output wrong for cycle kind");

    a_ready_stall: assert property (
        q.bst == S_T3 && !ready |=> q.bst == S_T3 && !q.grant)
        else $error("cycle left T3 without ready");

    a_lock_nogrant: assert property (
        !q.lock_n |=> !$rose(q.grant))
        else $error("hold granted while lock asserted");

    a_grant_keeps: assert property (
        q.grant && holdReq && !q.refPend |=> q.grant)
        else $error("grant dropped while hold still requested");

    a_yield_waits: assert property (
        q.bst == S_YIELD && holdReq |=> !q.grant && q.ctrlFlt && q.dataFlt)
        else $error("bus retaken before hold released");

    a_halt_exit: assert property (
        q.bst == S_HALT && intOk |=> sq_haltLeft)
        else $error("halt not left on interrupt");

    a_reload_first: assert property (
        q.cycStart && $past(q.reloadCnt) != RELOAD_NONE && !$past(q.cycStart)
        && $past(q.bst) == S_IDLE && !$past(refOk) |-> q.kind == K_MEMRD)
        else $error("reload read not issued first after halt");

    a_wait_suspend: assert property (
        waitExec && q.testSync && !intOk |=> q.suspend)
        else $error("wait not suspended while test high");

    a_refresh_first: assert property (
        q.bst == S_IDLE && refOk && holdReq |=> q.cycStart && q.kind == K_REFRESH && !q.grant)
        else $error("refresh did not precede hold grant");

    a_irq_acknowledge_locked: assert property (
        q.cycStart && q.kind == K_IRQ_ACKNOWLEDGE |-> !q.lock_n ##1 !q.grant)
        else $error("acknowledge cycle without lock");

endmodule

// >>> test/hold_master_model.sv
// Model of the external master that borrows the local bus
`timescale 1ns/1ns
module hold_master_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic want,
    input wire logic busGrantOut,
    output logic holdReq
);
    logic seen_ff;
    // Grant is latched so that a one-clock grant is never missed
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            holdReq <= 1'h0;
            seen_ff <= 1'h0;
        end else if (seen_ff && !busGrantOut) begin
            holdReq <= 1'h0;
            seen_ff <= 1'h0;
        end else begin
            holdReq <= want;
            seen_ff <= holdReq && (seen_ff || busGrantOut);
        end
    end
endmodule

// >>> test/tb_top.sv
// Testbench: hold, lock, refresh, halt, wait and direction of the arbiter
`timescale 1ns/1ns
module tb_top;
    import bus_arb_pkg::*;
    logic mclk, reset = 1'h1, want = 1'h0, refreshReq = 1'h0, nmiReq = 1'h0, irqReq = 1'h0;
    logic testIn = 1'h0, waitExec = 1'h0, lockPrefix = 1'h0, lockedInstrDone = 1'h0;
    logic cycleReq = 1'h0, ready = 1'h1, holdReq, busGrantOut, lockOut_n, transceiverDirection;
    logic prefixActive = 1'h0, repString = 1'h0, oddSecond = 1'h0, powerDown = 1'h0;
    logic ctrlFloat, dataFloat, execSuspended, haltActive, busCycleStart, busCycleDone, irqAccept;
    kind_t cycleKind = K_MEMRD, cycleKindOut;
    int failures = 0, total_checks = 0, cycles = 0, i;

    hold_master_model u_master (.mclk, .reset, .want, .busGrantOut, .holdReq);
    bus_hold_lock_halt_arbiter u_dut (.mclk, .reset, .holdReq, .refreshReq, .nmiReq, .irqReq,
        .testIn, .waitExec, .lockPrefix, .lockedInstrDone, .prefixActive, .repString,
        .cycleReq, .cycleKind, .oddSecond, .ready, .powerDown, .busGrantOut,
        .lockOut_n, .transceiverDirection, .ctrlFloat, .dataFloat, .execSuspended, .haltActive,
        .busCycleStart, .busCycleDone, .cycleKindOut, .irqAccept);

    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task smp;
        @(posedge mclk);
        #1;
    endtask
    task waitStart;
        for (i = 0; i < 40 && busCycleStart !== 1'h1; i++)
            smp();
    endtask
    task waitDone;
        for (i = 0; i < 40 && busCycleDone !== 1'h1; i++)
            smp();
    endtask
    task waitGrant(input logic v);
        for (i = 0; i < 60 && busGrantOut !== v; i++)
            smp();
        chk(busGrantOut, v);
    endtask
    task holdOff;
        @(posedge mclk);
        want <= 1'h0;
        waitGrant(1'h0);
        chk(ctrlFloat, 1'h0);
        chk(dataFloat, 1'h0);
    endtask
    task cyc(input kind_t k);
        @(posedge mclk);
        cycleReq <= 1'h1;
        cycleKind <= k;
        smp();
        waitStart();
        chk(busCycleStart, 1'h1);
        chk(cycleKindOut, k);
        chk(transceiverDirection, !(k inside {K_MEMRD, K_IORD, K_FETCH, K_IRQ_ACKNOWLEDGE}));
        @(posedge mclk);
        cycleReq <= 1'h0;
        waitDone();
        chk(busCycleDone, 1'h1);
    endtask
    task pulse(input logic lk);
        @(posedge mclk);
        lockPrefix <= lk;
        lockedInstrDone <= !lk;
        @(posedge mclk);
        lockPrefix <= 1'h0;
        lockedInstrDone <= 1'h0;
    endtask

    // ********************
    // Scenarios
    // ********************
    task tReset;
        chk(busGrantOut, 1'h0);
        chk(lockOut_n, 1'h1);
        chk(transceiverDirection, 1'h1);
        chk(irqAccept, 1'h0);
    endtask
    task tHold;
        @(posedge mclk);
        want <= 1'h1;
        repeat (2) smp();
        chk(ctrlFloat, 1'h1);
        chk(dataFloat, 1'h0);
        chk(busGrantOut, 1'h0);
        smp();
        chk(busGrantOut, 1'h1);
        chk(dataFloat, 1'h1);
        holdOff();
    endtask
    task tNotReady;
        @(posedge mclk);
        ready <= 1'h0;
        cycleReq <= 1'h1;
        smp();
        waitStart();
        @(posedge mclk);
        cycleReq <= 1'h0;
        want <= 1'h1;
        repeat (8) smp();
        chk(busGrantOut, 1'h0);
        chk(ctrlFloat, 1'h0);
        @(posedge mclk);
        ready <= 1'h1;
        waitGrant(1'h1);
        holdOff();
    endtask
    task tOdd;
        @(posedge mclk);
        cycleReq <= 1'h1;
        cycleKind <= K_MEMWR;
        oddSecond <= 1'h1;
        want <= 1'h1;
        smp();
        @(posedge mclk);
        cycleReq <= 1'h0;
        waitDone();
        chk(busCycleStart, 1'h1);
        chk(ctrlFloat, 1'h0);
        @(posedge mclk);
        oddSecond <= 1'h0;
        waitGrant(1'h1);
        holdOff();
    endtask
    task tRepLock;
        pulse(1'h1);
        cyc(K_MEMRD);
        @(posedge mclk);
        repString <= 1'h1;
        prefixActive <= 1'h1;
        irqReq <= 1'h1;
        smp();
        chk(irqAccept, 1'h1);
        chk(lockOut_n, 1'h0);
        @(posedge mclk);
        repString <= 1'h0;
        prefixActive <= 1'h0;
        irqReq <= 1'h0;
        cyc(K_FETCH);
        chk(lockOut_n, 1'h1);
    endtask
    task tPrefix;
        @(posedge mclk);
        prefixActive <= 1'h1;
        refreshReq <= 1'h1;
        irqReq <= 1'h1;
        @(posedge mclk);
        refreshReq <= 1'h0;
        repeat (4) smp();
        chk(busCycleStart, 1'h0);
        chk(irqAccept, 1'h0);
        @(posedge mclk);
        prefixActive <= 1'h0;
        waitStart();
        chk(cycleKindOut, K_REFRESH);
        chk(irqAccept, 1'h1);
        irqReq <= 1'h0;
        waitDone();
    endtask
    task tDir;
        for (int k = 0; k < 6; k++) begin
            cyc(kind_t'(k));
            if (k == 3) begin
                waitStart();
                chk(lockOut_n, 1'h0);
                smp();
                waitDone();
            end
        end
        chk(lockOut_n, 1'h1);
    endtask
    task tLock;
        pulse(1'h1);
        cyc(K_MEMRD);
        chk(lockOut_n, 1'h0);
        want <= 1'h1;
        cyc(K_MEMWR);
        pulse(1'h0);
        repeat (4) smp();
        chk(busGrantOut, 1'h0);
        cyc(K_FETCH);
        chk(lockOut_n, 1'h1);
        waitGrant(1'h1);
        holdOff();
    endtask
    task tRefresh;
        want <= 1'h1;
        waitGrant(1'h1);
        refreshReq <= 1'h1;
        @(posedge mclk);
        refreshReq <= 1'h0;
        waitGrant(1'h0);
        chk(ctrlFloat, 1'h1);
        waitStart();
        chk(cycleKindOut, K_REFRESH);
        waitGrant(1'h1);
        holdOff();
    endtask
    task tBoth;
        want <= 1'h1;
        @(posedge mclk);
        refreshReq <= 1'h1;
        @(posedge mclk);
        refreshReq <= 1'h0;
        smp();
        for (i = 0; i < 20 && busCycleStart !== 1'h1 && busGrantOut !== 1'h1; i++)
            smp();
        chk(busCycleStart, 1'h1);
        chk(busGrantOut, 1'h0);
        chk(cycleKindOut, K_REFRESH);
        waitGrant(1'h1);
        holdOff();
    endtask
    task tHalt;
        cyc(K_HALT);
        smp();
        chk(haltActive, 1'h1);
        powerDown <= 1'h1;
        want <= 1'h1;
        repeat (4) smp();
        chk(busGrantOut, 1'h0);
        chk(haltActive, 1'h1);
        powerDown <= 1'h0;
        waitGrant(1'h1);
        holdOff();
        smp();
        chk(haltActive, 1'h1);
        nmiReq <= 1'h1;
        repeat (2) smp();
        chk(haltActive, 1'h0);
        for (int n = 0; n < 2; n++) begin
            waitStart();
            chk(cycleKindOut, K_MEMRD);
            smp();
            waitDone();
        end
        nmiReq <= 1'h0;
    endtask
    task tWait;
        waitExec <= 1'h1;
        testIn <= 1'h1;
        repeat (6) smp();
        chk(execSuspended, 1'h1);
        testIn <= 1'h0;
        smp();
        chk(execSuspended, 1'h1);
        repeat (6) smp();
        chk(execSuspended, 1'h0);
        testIn <= 1'h1;
        repeat (6) smp();
        chk(execSuspended, 1'h1);
        irqReq <= 1'h1;
        repeat (3) smp();
        chk(execSuspended, 1'h0);
        chk(irqAccept, 1'h1);
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'h0;
        smp();
        tReset();
        tHold();
        tNotReady();
        tOdd();
        tDir();
        tLock();
        tRepLock();
        tPrefix();
        tRefresh();
        tBoth();
        tHalt();
        tWait();
        end_of_test();
    end
endmodule
